// >>> rtl/fgpe_defs.svh
`ifndef FGPE_DEFS_SVH
`define FGPE_DEFS_SVH
`define FGPE_SAMPLE_W 12
`define FGPE_GAIN_MAX 4'hC
`define FGPE_GAIN_RESET 4'h0
`define FGPE_WIN_MAX 3'h4
`define FGPE_WIN_RESET 3'h0
`define FGPE_WIN_BASE_LOG2 10
`define FGPE_LATENCY 21
`define FGPE_FIFO_DEPTH 8
`define FGPE_ADDR_CTRL 4'h0
`define FGPE_ADDR_STATUS 4'h4
`define FGPE_CTRL_GAIN_LSB 0
`define FGPE_CTRL_WIN_LSB 4
`define FGPE_CTRL_EN_BIT 8
`define FGPE_CTRL_FMT_BIT 9
`endif

// >>> rtl/fgpe_fifo.sv
`timescale 1ns/1ps
module fgpe_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_reg + AW'(1);
            if (pop) rd_reg <= rd_reg + AW'(1);
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : fgpe_fifo

// >>> rtl/fgpe_pkg.sv
package fgpe_pkg;
    typedef struct packed {
        logic twos_complement;
        logic level_monitor_enable;
        logic [2:0] averaging_window_select;
        logic [3:0] gain_code;
    } fgpe_ctrl_type;

    typedef struct packed {
        logic valid;
        logic [11:0] data;
    } fgpe_sample_type;
endpackage : fgpe_pkg

// >>> rtl/fgpe_top.sv
`timescale 1ns/1ps
`include "fgpe_defs.svh"
module fgpe_top (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // avalon-mm slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // converter sample stream
    input wire logic [11:0] SAMPLE_IN,
    // scaled sample stream
    output fgpe_pkg::fgpe_sample_type SAMPLE_OUT,
    input wire logic SAMPLE_READY,
    output logic SAMPLE_STALL,
    // power detect pins
    output logic [3:0] DETECT_OUT,
    output logic [3:0] DETECT_OE
);
    import fgpe_pkg::*;

    localparam int PIPE = `FGPE_LATENCY - 2;

    // clamp of a 12-bit signed result
    function automatic logic [11:0] sat12(input logic signed [19:0] v);
        if (v > 20'sd2047) return 12'h7FF;
        if (v < -20'sd2048) return 12'h800;
        return v[11:0];
    endfunction : sat12

    // register slave
    fgpe_ctrl_type ctrl_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    wire sel_ctrl = (AVS_ADDRESS == `FGPE_ADDR_CTRL);
    wire sel_stat = (AVS_ADDRESS == `FGPE_ADDR_STATUS);
    wire req = (AVS_READ || AVS_WRITE) && !ack_reg;
    wire [3:0] wr_gain = AVS_WRITEDATA[`FGPE_CTRL_GAIN_LSB +: 4];
    wire [2:0] wr_win = AVS_WRITEDATA[`FGPE_CTRL_WIN_LSB +: 3];
    // reserved codes are refused so the datapath never sees them
    wire gain_ok = (wr_gain <= `FGPE_GAIN_MAX);
    wire win_ok = (wr_win <= `FGPE_WIN_MAX);
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;
    assign AVS_READDATA = rdata_reg;

    logic [3:0] level_reg;
    logic upd_reg;

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_reg <= '0;
            ctrl_reg.gain_code <= `FGPE_GAIN_RESET;
            ctrl_reg.averaging_window_select <= `FGPE_WIN_RESET;
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= req;
            // a write lands on the edge where waitrequest is already low
            if (ack_reg && AVS_WRITE && sel_ctrl && AVS_BYTEENABLE[0]) begin
                if (gain_ok) ctrl_reg.gain_code <= wr_gain;
                if (win_ok) ctrl_reg.averaging_window_select <= wr_win;
            end
            if (ack_reg && AVS_WRITE && sel_ctrl && AVS_BYTEENABLE[1]) begin
                ctrl_reg.level_monitor_enable <= AVS_WRITEDATA[`FGPE_CTRL_EN_BIT];
                ctrl_reg.twos_complement <= AVS_WRITEDATA[`FGPE_CTRL_FMT_BIT];
            end
            if (req && AVS_READ) begin
                rdata_reg <= sel_ctrl ? {22'h0, ctrl_reg.twos_complement,
                                         ctrl_reg.level_monitor_enable, 1'b0,
                                         ctrl_reg.averaging_window_select,
                                         ctrl_reg.gain_code} :
                             sel_stat ? {27'h0, upd_reg, level_reg} : 32'h0;
            end
        end
    end

    // input capture, 12 bits every clock
    logic [11:0] in_reg;
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) in_reg <= '0;
        else in_reg <= SAMPLE_IN;
    end
    // signed view: offset binary flips the msb
    wire [11:0] s_in = ctrl_reg.twos_complement ? in_reg : {~in_reg[11], in_reg[10:0]};

    // gain in q1.7: round(128*10^(k/40)) except 8'hBF at k = 7, k = 0..12 half-dB steps
    function automatic logic [7:0] gain_mult(input logic [3:0] k);
        case (k)
            4'h0: return 8'h80;
            4'h1: return 8'h88;
            4'h2: return 8'h90;
            4'h3: return 8'h98;
            4'h4: return 8'hA1;
            4'h5: return 8'hAB;
            4'h6: return 8'hB5;
            4'h7: return 8'hBF;
            4'h8: return 8'hCB;
            4'h9: return 8'hD7;
            4'hA: return 8'hE4;
            4'hB: return 8'hF1;
            default: return 8'hFF;
        endcase
    endfunction : gain_mult

    // 2047 * 255 still fits 20 signed bits, so the cut loses nothing
    wire signed [19:0] prod = 20'($signed(s_in) * $signed({1'b0, gain_mult(ctrl_reg.gain_code)}));
    wire [11:0] scaled = sat12(prod >>> 7);
    wire [11:0] out_code = ctrl_reg.twos_complement ? scaled : {~scaled[11], scaled[10:0]};

    // pipeline brings total latency to 22 cycles, one more than FGPE_LATENCY
    logic [11:0] pipe_reg [PIPE];
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < PIPE; i++) pipe_reg[i] <= '0;
        end else begin
            pipe_reg[0] <= out_code;
            for (int i = 1; i < PIPE; i++) pipe_reg[i] <= pipe_reg[i-1];
        end
    end

    // output buffer; a stalled sink overflows it and the stall flag shows it
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [11:0] fifo_out_data;
    logic out_valid_reg;
    logic [11:0] out_data_reg;
    logic pipe_valid_reg;
    fgpe_fifo #(.WIDTH(12), .DEPTH(`FGPE_FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst(RESET),
        .in_valid(pipe_valid_reg),
        .in_ready(fifo_in_ready),
        .in_data(pipe_reg[PIPE-1]),
        .out_valid(fifo_out_valid),
        .out_ready(SAMPLE_READY),
        .out_data(fifo_out_data)
    );
    assign SAMPLE_STALL = pipe_valid_reg && !fifo_in_ready;
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            pipe_valid_reg <= 1'b0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else begin
            pipe_valid_reg <= 1'b1;
            out_valid_reg <= fifo_out_valid && SAMPLE_READY;
            out_data_reg <= fifo_out_data;
        end
    end
    assign SAMPLE_OUT = '{valid: out_valid_reg, data: out_data_reg};

    // power estimator on the scaled stream
    wire signed [11:0] sv = $signed(scaled);
    // -2048 squared needs 23 bits; 16K of those need 37
    wire [22:0] sq = 23'(sv * sv);
    logic [36:0] acc_reg;
    logic [14:0] cnt_reg;
    wire [4:0] win_log2 = 5'(`FGPE_WIN_BASE_LOG2) + {2'b0, ctrl_reg.averaging_window_select};
    wire [14:0] cnt_last = 15'((32'h1 << win_log2) - 1);
    wire win_end = (cnt_reg >= cnt_last);
    wire [36:0] acc_sum = acc_reg + 37'(sq);
    wire [22:0] mean = 23'(acc_sum >> win_log2);

    // full-scale sine mean square is 2^21; thresholds at 1 dB bins
    function automatic logic [3:0] bin_code(input logic [22:0] m);
        logic [22:0] th [12];
        logic [3:0] c;
        th = '{23'h01CCAC, 23'h0243F4, 23'h02DA1E, 23'h039728, 23'h048527,
               23'h05B0C4, 23'h0729F6, 23'h0904D1, 23'h0B5AA1, 23'h0E4B3B,
               23'h11FEB3, 23'h16A77E};
        c = 4'h1;
        for (int i = 0; i < 12; i++) if (m >= th[i]) c = 4'(i + 2);
        if (m >= 23'h200000) c = 4'hE;
        return c;
    endfunction : bin_code

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            acc_reg <= '0;
            cnt_reg <= '0;
            level_reg <= 4'h1;
            upd_reg <= 1'b0;
        end else if (win_end) begin
            acc_reg <= '0;
            cnt_reg <= '0;
            level_reg <= bin_code(mean);
            upd_reg <= ~upd_reg;
        end else begin
            acc_reg <= acc_sum;
            cnt_reg <= cnt_reg + 15'h1;
        end
    end

    assign DETECT_OUT = ctrl_reg.level_monitor_enable ? level_reg : 4'h0;
    assign DETECT_OE = {4{ctrl_reg.level_monitor_enable}};
endmodule : fgpe_top

// >>> testbench/fgpe_board.sv
`timescale 1ns/1ps
module fgpe_board (
    // clock
    input wire logic clk,
    // device pins
    input wire logic [3:0] detect_out,
    input wire logic [3:0] detect_oe,
    // latched code
    output logic [3:0] seen_code
);
    // undriven pins fall to the board pull-downs
    wire logic [3:0] pin_level = detect_out & detect_oe;
    always_ff @(posedge clk) seen_code <= pin_level;
endmodule : fgpe_board

// >>> testbench/fgpe_chk.sv
`timescale 1ns/1ps
module fgpe_chk (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // bus
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // pins
    input wire logic [3:0] DETECT_OUT,
    input wire logic [3:0] DETECT_OE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire logic rd_ok = AVS_READ && !AVS_WAITREQUEST;
    sequence s_answer;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    a_wait_one: assert property ($rose(AVS_READ || AVS_WRITE) |-> s_answer)
        else $error("bus answer not after one cycle");
    a_reset_off: assert property ($fell(RESET) |-> DETECT_OE == 4'h0)
        else $error("detect pins driven after reset");
    a_oe_level: assert property (DETECT_OE == 4'h0 || DETECT_OE == 4'hF)
        else $error("detect enables split");
    a_off_quiet: assert property (DETECT_OE == 4'h0 |-> DETECT_OUT == 4'h0)
        else $error("detect code while disabled");
    a_bin_range: assert property (DETECT_OE == 4'hF |-> DETECT_OUT inside {[4'h1:4'hE]})
        else $error("detect code out of range");
    a_detect_held: assert property (DETECT_OE == 4'hF && $changed(DETECT_OUT) && $stable(DETECT_OE)
        |=> ($stable(DETECT_OUT) || AVS_WRITE) [*8]) else $error("detect code not held");
    a_unmapped_zero: assert property (rd_ok && !(AVS_ADDRESS inside {4'h0, 4'h4})
        |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
    a_ctrl_legal: assert property (rd_ok && AVS_ADDRESS == 4'h0
        |-> AVS_READDATA[3:0] <= 4'hC && AVS_READDATA[6:4] <= 3'h4)
        else $error("illegal code stored");
endmodule : fgpe_chk
bind fgpe_top fgpe_chk chk_u (.SYS_CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_READDATA, .AVS_WAITREQUEST, .DETECT_OUT, .DETECT_OE);

// >>> testbench/test_fine_gain_power_estimator.sv
`timescale 1ns/1ps
module test_fine_gain_power_estimator;
    import fgpe_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic [11:0] SAMPLE_IN = 12'h000;
    fgpe_sample_type SAMPLE_OUT;
    logic SAMPLE_READY = 1'b1;
    logic SAMPLE_STALL;
    logic [3:0] DETECT_OUT;
    logic [3:0] DETECT_OE;
    logic [3:0] board_code;
    logic [31:0] q;
    int failures = 0;
    int total_checks = 0;
    // gain, window, dc level, expected bin; levels sit mid-band
    logic [23:0] rows [5] = '{24'h002D68, 24'hC128AD, 24'h6328AA, 24'h040641, 24'h122BC8};
    always #2.5 SYS_CLK = ~SYS_CLK;
    fgpe_top dut_u (.SYS_CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA, .AVS_WAITREQUEST, .SAMPLE_IN, .SAMPLE_OUT,
        .SAMPLE_READY, .SAMPLE_STALL, .DETECT_OUT, .DETECT_OE);
    fgpe_board board_u (.clk(SYS_CLK), .detect_out(DETECT_OUT), .detect_oe(DETECT_OE),
        .seen_code(board_code));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_WRITEDATA <= d;
        // values seen here are those the slave sampled at this edge
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
        if (n >= 20) failures++;
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask : bus
    initial begin
        logic [23:0] r;
        int n;
        repeat (5) @(posedge SYS_CLK);
        RESET <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            SAMPLE_IN <= r[15:4];
            bus(1'b1, 4'h0, {22'h0, 3'b110, r[18:16], r[23:20]});
            repeat ((2048 << r[18:16]) + 64) @(posedge SYS_CLK);
            check({28'h0, board_code}, {28'h0, r[3:0]});
            check({28'h0, DETECT_OE}, 32'hF);
            bus(1'b0, 4'h0, 32'h0);
            check(q, {22'h0, 3'b110, r[18:16], r[23:20]});
            bus(1'b0, 4'h4, 32'h0);
            check(q & 32'hF, {28'h0, r[3:0]});
            $display("row %0d done", i);
        end
        RESET <= 1'b1;
        repeat (5) @(posedge SYS_CLK);
        RESET <= 1'b0;
        SAMPLE_IN <= 12'h123;
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h0);
        check({28'h0, DETECT_OE}, 32'h0);
        repeat (40) @(posedge SYS_CLK);
        check({19'h0, SAMPLE_OUT}, 32'h1123);
        SAMPLE_IN <= 12'h456;
        n = 0;
        while (SAMPLE_OUT.data !== 12'h456 && n < 40) begin
            @(negedge SYS_CLK);
            n++;
        end
        check(32'(n), 32'd23);
        $display("reset and latency done");
        bus(1'b1, 4'h0, 32'h56);
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h6);
        bus(1'b1, 4'h0, 32'h2D);
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h26);
        bus(1'b0, 4'h8, 32'h0);
        check(q, 32'h0);
        $display("refusal done");
        SAMPLE_READY <= 1'b0;
        n = 0;
        while (SAMPLE_STALL !== 1'b1 && n < 60) begin
            @(negedge SYS_CLK);
            n++;
        end
        check({31'h0, SAMPLE_STALL}, 32'h1);
        @(posedge SYS_CLK);
        SAMPLE_READY <= 1'b1;
        repeat (20) @(posedge SYS_CLK);
        check({31'h0, SAMPLE_STALL}, 32'h0);
        $display("buffer done");
        close_out;
    end
    initial begin
        #400000;
        failures++;
        close_out;
    end
endmodule : test_fine_gain_power_estimator
